// file: logic/bus_lane_defs.vh
// Constants for the expansion-bus data lane and handshake block.
// Assumes a 250 MHz core clock and bus pins sampled through synchronisers.
`ifndef BUS_LANE_DEFS_VH
`define BUS_LANE_DEFS_VH
`define CLK_PERIOD_PS       4000
`define READY_HOLD_MAX_NS   2500
`define READY_HOLD_CYCLES   ((`READY_HOLD_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define WAIT_DEPTH          4'h4
`define ST_IDLE             3'h0
`define ST_START            3'h1
`define ST_CMD              3'h2
`define ST_DONE             3'h3
`define WID_8               2'h0
`define WID_16              2'h1
`define WID_32              2'h2
`define SIZE_WIDTH          2
`endif

// file: logic/bus_lane_handshake.v
// Expansion-bus data lane steering, ready and width handshakes, I/O slave data.
// Assumes bus pins arrive asynchronous to clock_in; open-drain pins drive low only.
// What this block does
// - 16-bit upper byte rides lanes 8-15
// - 32-bit byte enable 1 rides lanes 8-15
// - 8-bit device uses only lanes 0-7
// - 16-bit lower byte rides lanes 0-7
// - 32-bit byte enable 0 rides lanes 0-7
// - Each not-ready bus clock adds one wait
// - Slave pulls ready low at start end
// - Release ready at address-latch fall, bounded, low-only
// - 32-bit width indication combinational, never latched
// - 32-bit memory access completes in two clocks
// - Master samples 32-bit width at start end
// - 16-bit width indication after decode, unlatched
// - 16-bit master flags itself, watches 16-bit width
// - Assert I/O check on serious errors
// - Drive read data during read, address enable low
// - Hold read data until read negated sampled
// - Capture write data during write strobe
// - Write data valid before write strobe
`timescale 1ns/10ps
`include "bus_lane_defs.vh"
module bus_lane_handshake (
  input  wire        clock_in,
  input  wire        nrst_in,
  input  wire        bclk_in,
  input  wire        bale_in,
  input  wire        start_n_in,
  input  wire        cmd_n_in,
  input  wire        iorc_n_in,
  input  wire        iowc_n_in,
  input  wire        aen_in,
  input  wire        dack_in,
  input  wire        sbhe_n_in,
  input  wire        sa0_in,
  input  wire [3:0]  be_n_in,
  input  wire        exrdy_in,
  input  wire        ex32_n_in,
  input  wire        ex16_n_in,
  input  wire [31:0] data_in,
  input  wire        addr_hit_in,
  input  wire        mio_in,
  input  wire        slave_busy_in,
  input  wire        slave_wide_in,
  input  wire        parity_err_in,
  input  wire        sys_err_in,
  input  wire        m_req_in,
  input  wire        m_wide_in,
  input  wire [1:0]  m_rd_addr_in,
  input  wire [1:0]  s_addr_in,
  output reg  [31:0] data_out,
  output reg  [3:0]  data_oe_out,
  output wire        exrdy_out,
  output wire        exrdy_oe_out,
  output wire        ex32_out,
  output wire        ex32_oe_out,
  output wire        ex16_out,
  output wire        ex16_oe_out,
  output wire        iochk_out,
  output wire        iochk_oe_out,
  output reg         master16_n_out,
  output reg         m_done_out,
  output reg  [1:0]  m_width_out,
  output reg  [31:0] wr_word_out,
  output reg         wr_strobe_out
);
  reg  [12:0] sync1_q;
  reg  [13:0] sync2_q;
  reg  [31:0] dsync1_q;
  reg  [31:0] dsync2_q;
  reg         bclk_d1_q;
  reg         start_d1_q;
  reg         iowc_d1_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         hold_q;
  reg  [11:0] hold_cnt_q;
  reg  [3:0]  be_sync1_q;
  reg  [3:0]  be_sync2_q;
  reg         width_ok_q;
  reg         rd_drive_q;
  reg         iochk_q;
  reg  [1:0]  slave_width_q;
  wire [31:0] rd_word;

  wire bclk_s   = sync2_q[0];
  wire bale_s   = sync2_q[1];
  wire start_s  = sync2_q[2];
  wire cmd_s    = sync2_q[3];
  wire iorc_s   = sync2_q[4];
  wire iowc_s   = sync2_q[5];
  wire aen_s    = sync2_q[6];
  wire dack_s   = sync2_q[7];
  wire exrdy_s  = sync2_q[8];
  wire ex32_s   = sync2_q[9];
  wire ex16_s   = sync2_q[10];
  wire sbhe_s   = sync2_q[11];
  wire sa0_s    = sync2_q[12];
  wire bclk_fall = bclk_d1_q & ~bclk_s;
  wire start_end = ~start_d1_q & start_s;
  wire bale_fall = ~bale_s & sync2_q[13];

  // Steer a word into lanes by width; narrow parts move everything to low lanes
  function [31:0] steer;
    input [1:0]  width;
    input [31:0] word;
    input [3:0]  be_n;
    input        sbhe_n;
    input        sa0;
    begin
      steer = 32'h00000000;
      case (width)
        `WID_8: begin
          steer[7:0] = sa0 ? word[15:8] : word[7:0];
        end
        `WID_16: begin
          // Both lanes carry the same half of the double word, never a mix
          if (!sa0 || !be_n[2] || !be_n[0]) begin
            steer[7:0] = (be_n[0] && be_n[1]) ? word[23:16] : word[7:0];
          end
          if (!sbhe_n || !be_n[3] || !be_n[1]) begin
            steer[15:8] = (be_n[0] && be_n[1]) ? word[31:24] : word[15:8];
          end
        end
        default: begin
          if (!be_n[0]) begin
            steer[7:0] = word[7:0];
          end
          if (!be_n[1]) begin
            steer[15:8] = word[15:8];
          end
          if (!be_n[2]) begin
            steer[23:16] = word[23:16];
          end
          if (!be_n[3]) begin
            steer[31:24] = word[31:24];
          end
        end
      endcase
    end
  endfunction

  function [3:0] lane_oe;
    input [1:0] width;
    begin
      case (width)
        `WID_8:  lane_oe = 4'h1;
        `WID_16: lane_oe = 4'h3;
        default: lane_oe = 4'hF;
      endcase
    end
  endfunction

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_q    <= 13'h1FFF;
      be_sync1_q <= 4'hF;
      be_sync2_q <= 4'hF;
      sync2_q    <= 14'h3FFF;
      dsync1_q   <= 32'h00000000;
      dsync2_q   <= 32'h00000000;
      bclk_d1_q  <= 1'b1;
      start_d1_q <= 1'b1;
      iowc_d1_q  <= 1'b1;
    end else begin
      be_sync1_q <= be_n_in;
      be_sync2_q <= be_sync1_q;
      sync1_q <= {sa0_in, sbhe_n_in, ex16_n_in, ex32_n_in, exrdy_in, dack_in,
                  aen_in, iowc_n_in, iorc_n_in, cmd_n_in, start_n_in, bale_in, bclk_in};
      sync2_q    <= {bale_s, sync1_q[12:0]};
      dsync1_q   <= data_in;
      dsync2_q   <= dsync1_q;
      bclk_d1_q  <= bclk_s;
      start_d1_q <= start_s;
      iowc_d1_q  <= iowc_s;
    end
  end

  // Ready hold: lowered at start end, released on address-latch fall, on slave_busy_in dropping, or on timeout
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_q     <= 1'b0;
      hold_cnt_q <= 12'h000;
    end else if (hold_q) begin
      hold_cnt_q <= hold_cnt_q + 12'h001;
      if (bale_fall || !slave_busy_in ||
          hold_cnt_q >= `READY_HOLD_CYCLES - 1) begin
        hold_q <= 1'b0;
      end
    end else if (start_end && addr_hit_in && slave_busy_in) begin
      hold_q     <= 1'b1;
      hold_cnt_q <= 12'h000;
    end
  end

  assign exrdy_out    = 1'b0;
  assign exrdy_oe_out = hold_q;

  // Width indications come straight from decode so they track the address
  assign ex32_out     = 1'b0;
  assign ex32_oe_out  = addr_hit_in & slave_wide_in;
  assign ex16_out     = 1'b0;
  assign ex16_oe_out  = addr_hit_in;
  assign iochk_out    = 1'b0;
  assign iochk_oe_out = iochk_q;

  // I/O check stays asserted until reset; the CPU has no clear path here
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      iochk_q <= 1'b0;
    end else if (parity_err_in || sys_err_in) begin
      iochk_q <= 1'b1;
    end
  end

  // Master sequence
  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_IDLE:  if (m_req_in) state_d = `ST_START;
      `ST_START: if (start_end) state_d = `ST_CMD;
      `ST_CMD: begin
        if (bclk_fall && exrdy_s && width_ok_q) begin
          state_d = `ST_DONE;
        end
      end
      `ST_DONE:  state_d = `ST_IDLE;
      default:   state_d = `ST_IDLE;
    endcase
  end

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q        <= `ST_IDLE;
      width_ok_q     <= 1'b0;
      m_width_out    <= `WID_8;
      m_done_out     <= 1'b0;
      master16_n_out <= 1'b1;
    end else begin
      state_q    <= state_d;
      m_done_out <= (state_d == `ST_DONE);
      if (state_q == `ST_IDLE && m_req_in) begin
        master16_n_out <= m_wide_in;
        width_ok_q     <= 1'b0;
      end
      if (state_q == `ST_START && start_end) begin
        if (!ex32_s && m_wide_in) begin
          m_width_out <= `WID_32;
          width_ok_q  <= 1'b1;
        end else if (!ex16_s) begin
          m_width_out <= `WID_16;
          width_ok_q  <= 1'b1;
        end else begin
          m_width_out <= `WID_8;
        end
      end
      if (state_q == `ST_CMD && !width_ok_q) begin
        if ((m_wide_in && !ex32_s) || (!m_wide_in && !ex16_s)) begin
          width_ok_q <= 1'b1;
        end
      end
      if (state_d == `ST_IDLE) begin
        master16_n_out <= 1'b1;
      end
    end
  end

  lane_store store (
    .clock_in    (clock_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (wr_strobe_out),
    .wr_addr_in  (s_addr_in),
    .wr_be_in    (~be_sync2_q),
    .wr_data_in  (wr_word_out),
    .rd_addr_in  (state_q == `ST_IDLE ? s_addr_in : m_rd_addr_in),
    .rd_data_out (rd_word)
  );

  // Slave read drive: held until negated read strobe is seen
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_drive_q    <= 1'b0;
      slave_width_q <= `WID_8;
      data_out      <= 32'h00000000;
      data_oe_out   <= 4'h0;
      wr_word_out   <= 32'h00000000;
      wr_strobe_out <= 1'b0;
    end else begin
      slave_width_q <= slave_wide_in ? `WID_32 : `WID_16;
      if (!iorc_s && addr_hit_in && !mio_in && (!aen_s || !dack_s)) begin
        rd_drive_q <= 1'b1;
      end else if (iorc_s) begin
        rd_drive_q <= 1'b0;
      end
      wr_strobe_out <= 1'b0;
      if (!iowc_s && iowc_d1_q && addr_hit_in && (!aen_s || !dack_s)) begin
        wr_word_out   <= dsync2_q;
        wr_strobe_out <= 1'b1;
      end
      if (state_q == `ST_CMD || state_q == `ST_DONE) begin
        data_out    <= steer(m_width_out, rd_word, be_sync2_q, sbhe_s, sa0_s);
        data_oe_out <= lane_oe(m_width_out);
      end else if (rd_drive_q) begin
        data_out    <= steer(slave_width_q, rd_word, be_sync2_q, sbhe_s, sa0_s);
        data_oe_out <= lane_oe(slave_width_q);
      end else begin
        data_oe_out <= 4'h0;
      end
    end
  end
endmodule

// file: logic/lane_store.v
// Small register file holding the adapter's slave-side I/O data words.
// Assumes a single writer and registered read data, one clock.
`timescale 1ns/10ps
module lane_store (
  input  wire        clock_in,
  input  wire        nrst_in,
  input  wire        wr_en_in,
  input  wire [1:0]  wr_addr_in,
  input  wire [3:0]  wr_be_in,
  input  wire [31:0] wr_data_in,
  input  wire [1:0]  rd_addr_in,
  output reg  [31:0] rd_data_out
);
  reg [31:0] mem_q [0:3];
  integer    i;
  integer    b;

  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        mem_q[i] <= 32'h00000000;
      end
      rd_data_out <= 32'h00000000;
    end else begin
      if (wr_en_in) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (wr_be_in[b]) begin
            mem_q[wr_addr_in][b*8 +: 8] <= wr_data_in[b*8 +: 8];
          end
        end
      end
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule

// file: verification/bus_board_model.sv
// Board and slave model: free bus clock, START then CMD, ready waits, width replies.
// Assumes go_in is raised and held until completion, then lowered.
`timescale 1ns/10ps
module bus_board_model (
  input  wire       go_in,
  input  wire [3:0] waits_in,
  input  wire [1:0] reply_in,
  output reg        bclk_out = 1'b0,
  output reg        start_n_out = 1'b1,
  output reg        cmd_n_out = 1'b1,
  output reg        exrdy_out = 1'b1,
  output reg        ex32_n_out = 1'b1,
  output reg        ex16_n_out = 1'b1
);
  integer i;
  // Bus clock runs free, as on the real backplane
  always #16 bclk_out = ~bclk_out;
  always begin
    wait (go_in);
    @(posedge bclk_out);
    start_n_out <= 1'b0;
    ex32_n_out <= reply_in != 2'h0;
    ex16_n_out <= reply_in != 2'h1;
    @(posedge bclk_out);
    start_n_out <= 1'b1;
    cmd_n_out <= 1'b0;
    exrdy_out <= waits_in == 4'h0;
    for (i = 0; i < waits_in; i = i + 1) @(posedge bclk_out);
    exrdy_out <= 1'b1;
    if (reply_in == 2'h2) ex32_n_out <= 1'b0;
    @(negedge bclk_out);
    @(posedge bclk_out);
    cmd_n_out <= 1'b1;
    ex32_n_out <= 1'b1;
    ex16_n_out <= 1'b1;
    wait (!go_in);
  end
endmodule

// file: verification/bus_lane_handshake_sva.sv
// Port checker for the bus lane block.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module bus_lane_handshake_sva (
  input wire       clock_in,
  input wire       nrst_in,
  input wire       iorc_n_in,
  input wire       addr_hit_in,
  input wire       slave_wide_in,
  input wire       parity_err_in,
  input wire       sys_err_in,
  input wire [3:0] data_oe_out,
  input wire       exrdy_out,
  input wire       exrdy_oe_out,
  input wire       ex32_out,
  input wire       ex32_oe_out,
  input wire       ex16_out,
  input wire       ex16_oe_out,
  input wire       iochk_out,
  input wire       iochk_oe_out,
  input wire       m_done_out,
  input wire [1:0] m_width_out
);
  // One spare cycle for the registered release
  localparam int HOLD_MAX = 626;
  logic [9:0] hold_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) hold_q <= 10'h000;
    else hold_q <= exrdy_oe_out ? hold_q + 10'h001 : 10'h000;
  end
  a_ready_bounded: assert property (hold_q <= HOLD_MAX)
    else $error("ready held low too long");
  a_ready_low_only: assert property (exrdy_out == 1'b0)
    else $error("ready driven high");
  a_open_drain_low: assert property (!ex32_out && !ex16_out && !iochk_out)
    else $error("open-drain pin driven high");
  a_width_unlatched: assert property (!addr_hit_in |-> !ex32_oe_out && !ex16_oe_out)
    else $error("width flag without decode");
  a_width_decode: assert property (addr_hit_in |-> ex16_oe_out && ex32_oe_out == slave_wide_in)
    else $error("width flag missing on decode");
  a_error_raised: assert property ((parity_err_in || sys_err_in) |-> ##[0:3] iochk_oe_out)
    else $error("error not flagged");
  a_error_sticky: assert property (iochk_oe_out |=> iochk_oe_out)
    else $error("error flag dropped");
  a_done_pulse: assert property (m_done_out |=> !m_done_out)
    else $error("done longer than one cycle");
  a_done_width: assert property (m_done_out |-> m_width_out != 2'h3)
    else $error("no width at done");
  a_read_hold: assert property (data_oe_out != 4'h0 && !iorc_n_in |=> data_oe_out != 4'h0)
    else $error("read data dropped early");
endmodule
bind bus_lane_handshake bus_lane_handshake_sva chk (.*);

// file: verification/bus_lane_handshake_tb.sv
// Bench: master cycles against the board model, slave I/O writes and reads, error flag.
// Assumes the board model file and the design under logic/.
`timescale 1ns/10ps
module bus_lane_handshake_tb;
  logic clock_in, nrst_in, iorc_n, iowc_n, aen, hit, perr, serr, m_req, m_wide, mio, wide;
  logic [3:0] be_n, nwait;
  logic [1:0] reply, s_addr;
  logic [31:0] din, mem [4];
  wire bclk, start_n, cmd_n, rdy, ex32_n, ex16_n, exrdy_oe, ex32_oe, ex16_oe;
  wire iochk_oe, master16_n, m_done, wr_strobe;
  wire [31:0] data_out, wr_word;
  wire [3:0] data_oe;
  wire [1:0] m_width;
  integer n_fail = 0, comparisons = 0, seed = 97998, i;
  bus_board_model board (.go_in(m_req), .waits_in(nwait), .reply_in(reply), .bclk_out(bclk),
    .start_n_out(start_n), .cmd_n_out(cmd_n), .exrdy_out(rdy), .ex32_n_out(ex32_n),
    .ex16_n_out(ex16_n));
  bus_lane_handshake dut (.clock_in(clock_in), .nrst_in(nrst_in), .bclk_in(bclk),
    .bale_in(1'b0), .start_n_in(start_n), .cmd_n_in(cmd_n), .iorc_n_in(iorc_n),
    .iowc_n_in(iowc_n), .aen_in(aen), .dack_in(1'b1), .sbhe_n_in(1'b0), .sa0_in(1'b0),
    .be_n_in(be_n), .exrdy_in(rdy & ~exrdy_oe), .ex32_n_in(ex32_n & ~ex32_oe),
    .ex16_n_in(ex16_n & ~ex16_oe), .data_in(din), .addr_hit_in(hit), .mio_in(mio),
    .slave_busy_in(1'b0), .slave_wide_in(wide), .parity_err_in(perr), .sys_err_in(serr),
    .m_req_in(m_req), .m_wide_in(m_wide), .m_rd_addr_in(s_addr), .s_addr_in(s_addr),
    .data_out(data_out), .data_oe_out(data_oe), .exrdy_out(), .exrdy_oe_out(exrdy_oe),
    .ex32_out(), .ex32_oe_out(ex32_oe), .ex16_out(), .ex16_oe_out(ex16_oe), .iochk_out(),
    .iochk_oe_out(iochk_oe), .master16_n_out(master16_n), .m_done_out(m_done),
    .m_width_out(m_width), .wr_word_out(wr_word), .wr_strobe_out(wr_strobe));
  function logic [31:0] lanes(input logic [3:0] b);
    lanes = {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
  endfunction
  // Word slave with address bit 0 low and high enable asserted: one half, both lanes
  function logic [31:0] half(input logic [31:0] w, input logic [3:0] b);
    half = {16'h0000, (!b[0] || !b[1]) ? w[15:0] : w[31:16]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task do_reset;
    nrst_in = 1'b0;
    repeat (20) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clock_in);
  endtask
  task master(input logic w, input logic [1:0] r, input logic [3:0] n);
    integer k;
    m_wide = w;
    reply = r;
    nwait = n;
    mio = 1'($random(seed));
    m_req = 1'b1;
    @(negedge cmd_n);
    check(32'(master16_n), 32'(w));
    for (k = 0; k < 3000 && m_done !== 1'b1; k = k + 1) @(negedge clock_in);
    m_req = 1'b0;
    check(32'(rdy), 32'h1);
    check(32'(ex32_n), 32'(r == 2'h1));
    if (r != 2'h2) check(32'(m_width), (r == 2'h0) ? 32'h2 : 32'h1);
    @(posedge cmd_n);
    @(negedge clock_in);
  endtask
  task io_write(input logic [1:0] a, input logic [31:0] v, input logic h);
    integer k, got;
    s_addr = a;
    din = v;
    hit = h;
    be_n = 4'h0;
    @(negedge clock_in);
    iowc_n = 1'b0;
    got = 0;
    for (k = 0; k < 10; k = k + 1) begin
      @(negedge clock_in);
      if (wr_strobe === 1'b1) got = got + 1;
      if (wr_strobe === 1'b1) check(wr_word, v);
    end
    check(32'(got), 32'(h));
    iowc_n = 1'b1;
    @(negedge clock_in);
  endtask
  task io_read(input logic [1:0] a, input logic [3:0] b, input logic e);
    s_addr = a;
    be_n = b;
    aen = e;
    hit = 1'b1;
    wide = 1'($random(seed));
    @(negedge clock_in);
    iorc_n = 1'b0;
    repeat (8) @(negedge clock_in);
    check(32'(data_oe), e ? 32'h0 : wide ? 32'hF : 32'h3);
    if (!e && wide) check(data_out, mem[a] & lanes(b));
    if (!e && !wide) check(data_out, half(mem[a], b));
    iorc_n = 1'b1;
    repeat (8) @(negedge clock_in);
    check(32'(data_oe), 32'h0);
    aen = 1'b0;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    {iorc_n, iowc_n, m_wide, mio, wide} = 5'h1F;
    {aen, hit, perr, serr, m_req} = 5'h00;
    {be_n, nwait, reply, s_addr, din} = 44'h0;
    do_reset;
    // Reply kinds: wide slave, word slave, translated by the board
    for (i = 0; i < 6; i = i + 1) master(i % 3 != 1, 2'(i % 3), i == 0 ? 4'h0 : 4'($random(seed) & 7));
    $display("master cycles finished");
    mio = 1'b0;
    for (i = 0; i < 4; i = i + 1) mem[i] = $random(seed);
    for (i = 0; i < 4; i = i + 1) io_write(2'(i), mem[i], 1'b1);
    io_write(2'h0, ~mem[0], 1'b0);
    for (i = 0; i < 4; i = i + 1) io_read(2'(i), 4'($random(seed)), 1'b0);
    io_read(2'h1, 4'h0, 1'b1);
    $display("slave accesses finished");
    perr = 1'b1;
    @(negedge clock_in);
    perr = 1'b0;
    repeat (8) @(negedge clock_in);
    check(32'(iochk_oe), 32'h1);
    do_reset;
    check(32'(iochk_oe), 32'h0);
    serr = 1'b1;
    @(negedge clock_in);
    serr = 1'b0;
    repeat (4) @(negedge clock_in);
    check(32'(iochk_oe), 32'h1);
    $display("error flag finished");
    test_done;
  end
endmodule
